/* shared/ifcd_pkg.sv */
// Constants and types for the input function configuration decoder
package ifcd_pkg;
   localparam int CFG_W         = 16;
   localparam int MODE_BIT      = 15;
   localparam int ENC_BIT       = 10;
   localparam int RSV_HI        = 9;
   localparam int RSV_LO        = 6;
   localparam int IN2_HI        = 5;
   localparam int IN2_LO        = 3;
   localparam int IN1_HI        = 2;
   localparam int IN1_LO        = 0;
   localparam int FN_W          = 3;
   localparam int ENC_W         = 32;
   localparam logic [CFG_W-1:0] CFG_RESET = 16'h0000;

   typedef enum logic [FN_W-1:0] {
      IFCD_FN_GP    = 3'h0,
      IFCD_FN_CW    = 3'h1,
      IFCD_FN_CCW   = 3'h2,
      IFCD_FN_START = 3'h3,
      IFCD_FN_STOP  = 3'h4,
      IFCD_FN_ESTOP = 3'h5,
      IFCD_FN_HOME  = 3'h6,
      IFCD_FN_RSV   = 3'h7
   } ifcd_fn_e;
endpackage

/* core/ifcd_input_fn.sv */
// Per-input function decoder with edge detection and capture
`timescale 1ns/10ps
module ifcd_input_fn
   import ifcd_pkg::*;
(
   input  wire logic             clock,
   input  wire logic             rst_n,
   input  wire logic [FN_W-1:0]  func,
   input  wire logic             enc_en,
   input  wire logic             active,
   input  wire logic             jog_running,
   output logic                  cw_limit_q,
   output logic                  ccw_limit_q,
   output logic                  home_q,
   output logic                  start_q,
   output logic                  stop_q,
   output logic                  estop_q,
   output logic                  capture_q,
   output logic                  gp_state_q
);
   logic act_q;
   logic rise;
   logic edge_any;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) act_q <= 1'b0;
      else        act_q <= active;
   end

   assign rise     = active & ~act_q;
   assign edge_any = active ^ act_q;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cw_limit_q  <= 1'b0;
         ccw_limit_q <= 1'b0;
         home_q      <= 1'b0;
         gp_state_q  <= 1'b0;
      end else begin
         gp_state_q  <= active;                               // RULE5
         cw_limit_q  <= (func == IFCD_FN_CW) & active;        // RULE6
         ccw_limit_q <= (func == IFCD_FN_CCW) & active;       // RULE7
         home_q      <= (func == IFCD_FN_HOME) & active;      // RULE14
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         start_q   <= 1'b0;
         stop_q    <= 1'b0;
         estop_q   <= 1'b0;
         capture_q <= 1'b0;
      end else begin
         start_q   <= (func == IFCD_FN_START) & rise;         // RULE8 RULE10
         stop_q    <= (func == IFCD_FN_STOP) & rise
                      & jog_running;                          // RULE11
         estop_q   <= (func == IFCD_FN_ESTOP) & rise;         // RULE13
         capture_q <= enc_en & (((func == IFCD_FN_START) & edge_any) // RULE9
                    | ((func == IFCD_FN_STOP) & rise
                       & jog_running));                       // RULE12
      end
   end
endmodule

/* core/ifcd_top.sv */
// Configuration word 0 decode for the two discrete input functions
//
// Behaviour
// RULE1: bit 10 enables built-in encoder
// RULE2: host writes zero to bits 9-6
// RULE3: bits 5-3 select input 2 function
// RULE4: bits 2-0 select input 1 function
// RULE5: code 000 only reports input state
// RULE6: code 001 is clockwise limit
// RULE7: code 010 is counter-clockwise limit
// RULE8: code 011 starts held indexed move
// RULE9: code 011 with encoder captures every edge
// RULE10: rising edge launches pending indexed move
// RULE11: code 100 stops jog or registration
// RULE12: code 100 with encoder captures at stop
// RULE13: code 101 is emergency stop on edge
// RULE14: code 110 is home sensor
// RULE15: code 111 is reserved, host avoids
// RULE16: host programs encoder resolution with encoder
// RULE17: bit 15 selects configuration or command mode
// RULE18: same function on both inputs invalid; the code accepts code 000 on both
// RULE19: reserved function code rejected
// RULE20: invalid config stays command, flags error
`timescale 1ns/10ps
module ifcd_top
   import ifcd_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              rst_n,
   input  wire logic [CFG_W-1:0]  cfg_word,
   input  wire logic              cfg_write,
   input  wire logic              in1_active,
   input  wire logic              in2_active,
   input  wire logic              move_pending,
   input  wire logic              jog_running,
   input  wire logic [ENC_W-1:0]  enc_position,
   output logic                   config_mode_q,
   output logic                   config_error_q,
   output logic [CFG_W-1:0]       cfg_mirror_q,
   output logic                   enc_enable_q,
   output logic                   cw_limit_q,
   output logic                   ccw_limit_q,
   output logic                   home_q,
   output logic                   start_move_q,
   output logic                   ctrl_stop_q,
   output logic                   estop_q,
   output logic [ENC_W-1:0]       enc_capture_q,
   output logic                   enc_capture_valid_q,
   output logic                   in1_state_q,
   output logic                   in2_state_q
);
   ////////////////////////////////////////////////////////////////////////
   // Field pickers shared by the validity check and the decoders
   function automatic logic [FN_W-1:0] in1_fn(input logic [CFG_W-1:0] w);
      in1_fn = w[IN1_HI:IN1_LO];                              // RULE4
   endfunction

   function automatic logic [FN_W-1:0] in2_fn(input logic [CFG_W-1:0] w);
      in2_fn = w[IN2_HI:IN2_LO];                              // RULE3
   endfunction

   function automatic logic cfg_valid(input logic [CFG_W-1:0] w);
      logic [FN_W-1:0] f1;
      logic [FN_W-1:0] f2;
      f1 = in1_fn(w);
      f2 = in2_fn(w);
      cfg_valid = (w[RSV_HI:RSV_LO] == '0)                    // RULE2
                & (f1 != IFCD_FN_RSV) & (f2 != IFCD_FN_RSV)   // RULE19
                & ((f1 != f2) | (f1 == IFCD_FN_GP));          // RULE18
   endfunction

   // Only configuration-mode words are checked and stored
   logic [CFG_W-1:0] cfg_q;
   logic [FN_W-1:0]  fn1;
   logic [FN_W-1:0]  fn2;
   logic             wr_ok;
   logic             cfg_take;

   assign wr_ok    = cfg_valid(cfg_word);
   assign cfg_take = cfg_write & cfg_word[MODE_BIT];          // RULE17
   assign fn1      = in1_fn(cfg_q);
   assign fn2      = in2_fn(cfg_q);

   ////////////////////////////////////////////////////////////////////////
   // Rejected words leave the last good decode in force
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q <= CFG_RESET;
      end else if (cfg_take & wr_ok) begin
         cfg_q <= cfg_word;                                   // RULE20
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cfg_mirror_q <= CFG_RESET;
      end else if (cfg_take & wr_ok) begin
         cfg_mirror_q <= cfg_word;                            // RULE20
      end
   end

   // A command-mode word always drops back to command mode
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         config_mode_q <= 1'b0;
      end else if (cfg_write) begin
         config_mode_q <= cfg_take & wr_ok;                   // RULE17 RULE20
      end
   end

   // Error moves only on configuration-mode writes
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         config_error_q <= 1'b0;
      end else if (cfg_take) begin
         config_error_q <= ~wr_ok;                            // RULE20
      end
   end

   // Encoder enable follows the stored word, one clock behind
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) enc_enable_q <= 1'b0;
      else        enc_enable_q <= cfg_q[ENC_BIT];             // RULE1
   end

   ////////////////////////////////////////////////////////////////////////
   // Both inputs feed one set of function outputs, each keeps its own state output; equal codes other than 000 are refused
   logic cw1;
   logic ccw1;
   logic hm1;
   logic st1;
   logic sp1;
   logic es1;
   logic cp1;

   logic cw2;
   logic ccw2;
   logic hm2;
   logic st2;
   logic sp2;
   logic es2;
   logic cp2;

   ifcd_input_fn u_in1 (
      .clock       (clock),
      .rst_n       (rst_n),
      .func        (fn1),                                     // RULE4
      .enc_en      (cfg_q[ENC_BIT]),
      .active      (in1_active),
      .jog_running (jog_running),
      .cw_limit_q  (cw1),
      .ccw_limit_q (ccw1),
      .home_q      (hm1),
      .start_q     (st1),
      .stop_q      (sp1),
      .estop_q     (es1),
      .capture_q   (cp1),
      .gp_state_q  (in1_state_q)
   );

   ifcd_input_fn u_in2 (
      .clock       (clock),
      .rst_n       (rst_n),
      .func        (fn2),                                     // RULE3
      .enc_en      (cfg_q[ENC_BIT]),
      .active      (in2_active),
      .jog_running (jog_running),
      .cw_limit_q  (cw2),
      .ccw_limit_q (ccw2),
      .home_q      (hm2),
      .start_q     (st2),
      .stop_q      (sp2),
      .estop_q     (es2),
      .capture_q   (cp2),
      .gp_state_q  (in2_state_q)
   );

   ////////////////////////////////////////////////////////////////////////
   // Outputs lag the pins by two clocks; acceptable for mechanical switches
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) cw_limit_q <= 1'b0;
      else        cw_limit_q <= cw1 | cw2;                    // RULE6
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) ccw_limit_q <= 1'b0;
      else        ccw_limit_q <= ccw1 | ccw2;                 // RULE7
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) home_q <= 1'b0;
      else        home_q <= hm1 | hm2;                        // RULE14
   end

   // A start with no move waiting is dropped, not held
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) start_move_q <= 1'b0;
      else        start_move_q <= (st1 | st2) & move_pending; // RULE10
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) ctrl_stop_q <= 1'b0;
      else        ctrl_stop_q <= sp1 | sp2;                   // RULE11
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) estop_q <= 1'b0;
      else        estop_q <= es1 | es2;                       // RULE13
   end

   // Position sampled two clocks after the pin edge, with the valid flag
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) enc_capture_valid_q <= 1'b0;
      else        enc_capture_valid_q <= cp1 | cp2;           // RULE9 RULE12
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         enc_capture_q <= '0;
      end else if (cp1 | cp2) begin
         enc_capture_q <= enc_position;                       // RULE9 RULE12
      end
   end
endmodule

/* testbench/ifcd_top_sva.sv */
// Port assertions for the input function decoder
`timescale 1ns/10ps
module ifcd_top_sva
   import ifcd_pkg::*;
(
   input wire logic             clock,
   input wire logic             rst_n,
   input wire logic [CFG_W-1:0] cfg_word,
   input wire logic             cfg_write,
   input wire logic             in1_active,
   input wire logic             config_mode_q,
   input wire logic             config_error_q,
   input wire logic [CFG_W-1:0] cfg_mirror_q,
   input wire logic             enc_enable_q,
   input wire logic             cw_limit_q,
   input wire logic             estop_q,
   input wire logic [ENC_W-1:0] enc_position,
   input wire logic [ENC_W-1:0] enc_capture_q,
   input wire logic             enc_capture_valid_q,
   input wire logic             in1_state_q
);
   ////////////////////////////////////////////////////////////////////////
   logic [CFG_W-1:0] m1_q;
   wire logic [2:0]  fa = cfg_word[2:0];
   wire logic [2:0]  fb = cfg_word[5:3];
   wire logic        ok = cfg_word[9:6] == 4'h0 && fa != 3'h7 && fb != 3'h7
                          && (fa != fb || fa == 3'h0);
   wire logic        wr1 = cfg_write && cfg_word[MODE_BIT];
   // Timing checks only hold while the accepted word sits still
   wire logic        hd = m1_q == cfg_mirror_q;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) m1_q <= CFG_RESET;
      else m1_q <= cfg_mirror_q;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////
   a_cfg_accept: assert property (wr1 && ok |=> config_mode_q &&
      !config_error_q && cfg_mirror_q == $past(cfg_word))
      else $error("valid write not accepted");
   a_cfg_refuse: assert property (wr1 && !ok |=>
      !config_mode_q && config_error_q && $stable(cfg_mirror_q))
      else $error("invalid write accepted");
   a_cmd_mode: assert property (cfg_write && !cfg_word[MODE_BIT] |=>
      !config_mode_q && $stable(cfg_mirror_q)) else $error("mode 0 write");
   a_enc_follow: assert property (wr1 && ok ##1 !cfg_write |=>
      enc_enable_q == $past(cfg_word[ENC_BIT], 2)) else $error("enc enable");
   a_cw_level: assert property (hd && cfg_mirror_q[2:0] == 3'h1 &&
      in1_active ##1 hd |=> cw_limit_q) else $error("cw limit missing");
   a_gp_quiet: assert property (hd && cfg_mirror_q[5:0] == 6'h0
      ##1 hd |=> !cw_limit_q && !estop_q) else $error("general input acts");
   a_estop_edge: assert property (hd && cfg_mirror_q[2:0] == 3'h5 &&
      $rose(in1_active) ##1 hd |=> estop_q ##1 !estop_q)
      else $error("estop pulse wrong");
   a_cap_edge: assert property (hd && enc_enable_q &&
      cfg_mirror_q[2:0] == 3'h3 && $changed(in1_active) ##1 hd |=>
      enc_capture_valid_q && enc_capture_q == $past(enc_position))
      else $error("capture wrong");
   a_state_lag: assert property ($past(rst_n) |->
      in1_state_q == $past(in1_active)) else $error("input state lag");
   c_accept: cover property (wr1 && ok);
   c_refuse: cover property (wr1 && !ok);
   c_capture: cover property (enc_capture_valid_q);
endmodule

bind ifcd_top ifcd_top_sva ifcd_top_sva_inst (.*);

/* testbench/ifcd_host_model.sv */
// Host controller model that writes configuration words
`timescale 1ns/10ps
module ifcd_host_model
   import ifcd_pkg::*;
(
   input  wire logic        clock,
   output logic [CFG_W-1:0] cfg_word,
   output logic             cfg_write
);
   initial begin
      cfg_word = CFG_RESET;
      cfg_write = 1'b0;
   end
   // Raw lets a test set reserved bits on purpose
   task automatic put(input logic [CFG_W-1:0] w, input bit raw);
      @(posedge clock);
      cfg_word <= raw ? w : w & 16'hFC3F;
      cfg_write <= 1'b1;
      @(posedge clock);
      cfg_write <= 1'b0;
   endtask
endmodule

/* testbench/ifcd_top_tb.sv */
// Self-checking bench for the input function decoder
`timescale 1ns/10ps
module ifcd_top_tb
   import ifcd_pkg::*;
;
   logic clock, rst_n, in1_active, in2_active, move_pending, jog_running;
   logic config_mode_q, config_error_q, enc_enable_q, cw_limit_q, home_q;
   logic ccw_limit_q, start_move_q, ctrl_stop_q, estop_q, in1_state_q;
   logic enc_capture_valid_q, in2_state_q, cfg_write;
   logic [CFG_W-1:0] cfg_word, cfg_mirror_q, w;
   logic [ENC_W-1:0] enc_position, enc_capture_q, cap;
   logic [31:0]      ns, nt, ne, nc;
   logic [3:0]       lv;
   logic [15:0]      bad [5] = '{16'h8040, 16'h8007, 16'h8038, 16'h8009,
                                 16'h8024};
   int               fails = 0, tests_run = 0, cyc = 0;
   ifcd_top ifcd_top_inst (.*);
   ifcd_host_model ifcd_host_model_inst (.*);
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   task automatic chk(input string n, input logic [31:0] s, e);
      tests_run++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Pulse one input high five edges, then low, and gather outputs
   task automatic run(input int k);
      {lv, ns, nt, ne, nc} = '0;
      for (int i = 0; i < 10; i++) begin
         @(posedge clock);
         if (k == 1) in2_active <= i < 5;
         else in1_active <= i < 5;
         #1;
         lv = lv | {cw_limit_q, ccw_limit_q, home_q,
                    k == 1 ? in2_state_q : in1_state_q};
         ns = ns + start_move_q;
         nt = nt + ctrl_stop_q;
         ne = ne + estop_q;
         nc = nc + enc_capture_valid_q;
         if (enc_capture_valid_q === 1'b1) cap = enc_capture_q;
      end
   endtask
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         fails++;
         close_out();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {rst_n, in1_active, in2_active, move_pending, jog_running} = '0;
      enc_position = '0;
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      #1;
      chk("reset mode", config_mode_q, 0);
      chk("reset enc", enc_enable_q, 0);
      $display("test reset done");
      foreach (bad[i]) begin
         ifcd_host_model_inst.put(bad[i], 1'b1);
         #1;
         chk("refused mode", config_mode_q, 0);
         chk("error flag", config_error_q, 1);
         chk("mirror kept", cfg_mirror_q, 0);
      end
      ifcd_host_model_inst.put(16'h0403, 1'b0);
      #1;
      chk("command mode", config_mode_q, 0);
      ifcd_host_model_inst.put(16'h8000, 1'b0);
      #1;
      chk("both general", config_error_q, 0);
      $display("test config done");
      move_pending <= 1'b1;
      jog_running <= 1'b1;
      for (int e = 0; e < 2; e++) for (int k = 0; k < 2; k++)
         for (int c = 0; c < 7; c++) begin
            w = 16'(32'h8000 | e << 10 | c << 3 * k);
            enc_position <= 32'hA5A50000 | 32'(c);
            ifcd_host_model_inst.put(w, 1'b0);
            @(posedge clock);
            #1;
            chk("enc", enc_enable_q, e);
            run(k);
            chk("cw", lv[3], c == 1);
            chk("ccw", lv[2], c == 2);
            chk("home", lv[1], c == 6);
            chk("state", lv[0], 1);
            chk("start", ns, c == 3);
            chk("stop", nt, c == 4);
            chk("estop", ne, c == 5);
            chk("captures", nc, e * (c == 3 ? 2 : c == 4));
            if (nc !== 0) chk("cap value", cap, enc_position);
         end
      $display("test functions done");
      move_pending <= 1'b0;
      jog_running <= 1'b0;
      for (int c = 3; c < 5; c++) begin
         ifcd_host_model_inst.put(16'(32'h8400 | c), 1'b0);
         @(posedge clock);
         run(0);
         chk("no move", ns, 0);
         chk("no jog stop", nt, 0);
         chk("gated captures", nc, c == 3 ? 2 : 0);
      end
      $display("test gating done");
      close_out();
   end
endmodule
